// *** core/phr_pkg.sv ***
// Shared types and constants for the partition hot-reset controller
package phr_pkg;

    // Default number of downstream ports in a partition
    localparam int NUM_DS_DEFAULT = 4;

    // Reset value of control and status flags
    localparam logic FLAG_RST = 1'b0;

    // Sequencer states, one-hot
    typedef enum logic [3:0] {
        PHR_RUN    = 4'h1,
        PHR_HOLD   = 4'h2,
        PHR_TRAIN  = 4'h4,
        PHR_DEGRAD = 4'h8
    } phr_state_t;

    // Hot-reset trigger inputs from the upstream port
    typedef struct packed {
        logic dl_up;       // Upstream data link layer is up
        logic ts_hot_rst;  // TS1 with hot-reset bit seen upstream
        logic part_rst;    // Partition state field requests reset
    } phr_trig_t;

    // Routing qualifiers of a TLP seen by the partition core
    typedef struct packed {
        logic valid;       // TLP present
        logic to_ds;       // Destination is a downstream port
        logic self_gen;    // Originated by the switch toward root
    } phr_tlp_t;

    // Routing decision for one TLP
    typedef struct packed {
        logic fwd;         // Forward normally
        logic ur;          // Handle as unsupported request
        logic drop;        // Silently discard
    } phr_route_t;

endpackage

// *** core/phr_sync.sv ***
// Two-stage synchroniser for asynchronous inputs
`timescale 1ns/1ns
module phr_sync #(
    parameter int W = 1
) (
    input  wire logic         sys_clk,
    input  wire logic         rstn,
    input  wire logic         ce,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] q_r;
    logic [W-1:0] q_nxt;

    // Next values: shift through two stages while enabled
    always_comb begin
        meta_nxt = ce ? d : meta_r;
        q_nxt    = ce ? meta_r : q_r;
    end

    // Register stages
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            meta_r <= '0;
            q_r    <= '0;
        end else begin
            meta_r <= meta_nxt;
            q_r    <= q_nxt;
        end
    end

    assign q = q_r;
endmodule

// *** core/phr_ctrl.sv ***
// Partition hot-reset and upstream secondary bus reset controller
`timescale 1ns/1ns
// Functional notes
// - Trigger gone: train ports, resume operation
// - Suppress bit blocks link-down hot reset
// - Suppressed: LTSSM normal, reset actions skipped
// - Suppressed: keep peer-to-peer downstream forwarding
// - Suppressed: non-downstream TLPs not switch-originated are unsupported
// - Suppressed: drop switch-originated rootward TLPs silently
// - Suppressed: downstream ASPM ignores upstream state
// - TS1 hot-reset trigger always honoured
// - Secondary bus reset bit write starts reset
// - Link-up downstream ports send hot-reset TS1
// - Upstream DL_Down starts hot reset normally
// - Hold reset step while trigger persists
// - Reset non-sticky state, keep sticky classes
module phr_ctrl #(
    parameter int NUM_DS = phr_pkg::NUM_DS_DEFAULT
) (
    input  wire logic              sys_clk,
    input  wire logic              rstn,
    input  wire logic              ce,
    input  wire phr_pkg::phr_trig_t trig,
    input  wire logic              linkdown_reset_suppress,
    input  wire logic              secondary_bus_reset_bit,
    input  wire logic [NUM_DS-1:0] ds_link_up,
    input  wire logic [NUM_DS-1:0] ds_aspm_req,
    input  wire logic              us_aspm_ok,
    input  wire phr_pkg::phr_tlp_t tlp,
    output logic                   part_reset,
    output logic                   sticky_keep,
    output logic                   train_start,
    output logic                   us_ltssm_hot,
    output logic                   us_ltssm_detect,
    output logic                   degraded,
    output logic [NUM_DS-1:0]      ds_send_hot_ts1,
    output logic [NUM_DS-1:0]      ds_aspm_grant,
    output phr_pkg::phr_route_t    route
);
    // Parameter check
    if (NUM_DS < 1 || NUM_DS > 16) begin : g_chk
        $error("NUM_DS must be 1 to 16");
    end

    // Synchronised upstream trigger pins
    phr_pkg::phr_trig_t trig_s;
    logic               dl_up_d_r;
    logic               dl_up_d_nxt;
    logic               supp_r;
    logic               supp_nxt;

    phr_sync #(.W($bits(phr_pkg::phr_trig_t))) u_sync (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .ce      (ce),
        .d       (trig),
        .q       (trig_s)
    );

    phr_pkg::phr_state_t state_r;
    phr_pkg::phr_state_t state_nxt;

    logic              part_reset_r,  part_reset_nxt;
    logic              sticky_r,      sticky_nxt;
    logic              train_r,       train_nxt;
    logic              us_hot_r,      us_hot_nxt;
    logic              us_det_r,      us_det_nxt;
    logic              degraded_r,    degraded_nxt;
    logic [NUM_DS-1:0] ds_ts1_r,      ds_ts1_nxt;
    logic [NUM_DS-1:0] aspm_r,        aspm_nxt;
    phr_pkg::phr_route_t route_r,     route_nxt;

    logic link_fall;
    logic hot_cause;
    logic hold_cause;

    // Route decision for one TLP, given degraded mode
    function automatic phr_pkg::phr_route_t route_of(
        input phr_pkg::phr_tlp_t t,
        input logic              dgr
    );
        phr_pkg::phr_route_t r;
        r = '0;
        if (t.valid) begin
            if (!dgr) begin
                r.fwd = 1'b1;
            end else if (t.self_gen) begin
                r.drop = 1'b1;
            end else if (t.to_ds) begin
                r.fwd = 1'b1;
            end else begin
                r.ur = 1'b1;
            end
        end
        return r;
    endfunction

    // Trigger evaluation
    always_comb begin
        link_fall = dl_up_d_r & ~trig_s.dl_up;
        // Link-down starts hot reset only when not suppressed
        hot_cause = trig_s.ts_hot_rst | trig_s.part_rst
                  | (link_fall & ~linkdown_reset_suppress);
        // Reset persists while its cause is present
        hold_cause = trig_s.ts_hot_rst | trig_s.part_rst
                   | (~trig_s.dl_up & ~supp_r);
    end

    // Next-state and output logic
    always_comb begin
        state_nxt      = state_r;
        dl_up_d_nxt    = trig_s.dl_up;
        supp_nxt       = supp_r;
        part_reset_nxt = 1'b0;
        sticky_nxt     = 1'b0;
        train_nxt      = 1'b0;
        us_hot_nxt     = 1'b0;
        us_det_nxt     = 1'b0;
        degraded_nxt   = 1'b0;
        ds_ts1_nxt     = '0;
        // Latch suppress setting at the link-down instant
        if (link_fall) begin
            supp_nxt = linkdown_reset_suppress;
        end
        unique case (state_r)
            phr_pkg::PHR_RUN: begin
                if (hot_cause) begin
                    state_nxt = phr_pkg::PHR_HOLD;
                end else if (link_fall) begin
                    state_nxt = phr_pkg::PHR_DEGRAD;
                end
            end
            phr_pkg::PHR_HOLD: begin
                part_reset_nxt = 1'b1;
                sticky_nxt     = 1'b1;
                us_hot_nxt     = trig_s.ts_hot_rst;
                us_det_nxt     = ~trig_s.ts_hot_rst;
                ds_ts1_nxt     = ds_link_up;
                if (!hold_cause) begin
                    state_nxt = phr_pkg::PHR_TRAIN;
                end
            end
            phr_pkg::PHR_TRAIN: begin
                train_nxt = 1'b1;
                state_nxt = phr_pkg::PHR_RUN;
            end
            phr_pkg::PHR_DEGRAD: begin
                // LTSSM runs on its own; no reset actions taken
                degraded_nxt = 1'b1;
                if (trig_s.ts_hot_rst || trig_s.part_rst) begin
                    state_nxt = phr_pkg::PHR_HOLD;
                end else if (trig_s.dl_up) begin
                    state_nxt = phr_pkg::PHR_RUN;
                end
            end
        endcase
        // Secondary bus reset held while the bit is set
        if (secondary_bus_reset_bit && state_r != phr_pkg::PHR_HOLD) begin
            ds_ts1_nxt = ds_link_up;
        end
        // Downstream ASPM: upstream ignored in degraded mode
        aspm_nxt = ds_aspm_req
                 & {NUM_DS{degraded_nxt | us_aspm_ok}};
        route_nxt = route_of(tlp, degraded_nxt);
    end

    // State registers, frozen while clock enable is low
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_r      <= phr_pkg::PHR_RUN;
            dl_up_d_r    <= phr_pkg::FLAG_RST;
            supp_r       <= phr_pkg::FLAG_RST;
            part_reset_r <= phr_pkg::FLAG_RST;
            sticky_r     <= phr_pkg::FLAG_RST;
            train_r      <= phr_pkg::FLAG_RST;
            us_hot_r     <= phr_pkg::FLAG_RST;
            us_det_r     <= phr_pkg::FLAG_RST;
            degraded_r   <= phr_pkg::FLAG_RST;
            ds_ts1_r     <= '0;
            aspm_r       <= '0;
            route_r      <= '0;
        end else if (ce) begin
            state_r      <= state_nxt;
            dl_up_d_r    <= dl_up_d_nxt;
            supp_r       <= supp_nxt;
            part_reset_r <= part_reset_nxt;
            sticky_r     <= sticky_nxt;
            train_r      <= train_nxt;
            us_hot_r     <= us_hot_nxt;
            us_det_r     <= us_det_nxt;
            degraded_r   <= degraded_nxt;
            ds_ts1_r     <= ds_ts1_nxt;
            aspm_r       <= aspm_nxt;
            route_r      <= route_nxt;
        end
    end

    // Outputs straight from flip-flops
    assign part_reset      = part_reset_r;
    assign sticky_keep     = sticky_r;
    assign train_start     = train_r;
    assign us_ltssm_hot    = us_hot_r;
    assign us_ltssm_detect = us_det_r;
    assign degraded        = degraded_r;
    assign ds_send_hot_ts1 = ds_ts1_r;
    assign ds_aspm_grant   = aspm_r;
    assign route           = route_r;
endmodule

// *** verification/phr_ctrl_props.sv ***
// Assertion checker bound to the partition hot-reset controller
`timescale 1ns/1ns
module phr_ctrl_props #(
    parameter int NUM_DS = 4
) (
    input wire logic                sys_clk,
    input wire logic                rstn,
    input wire logic                ce,
    input wire phr_pkg::phr_trig_t  trig,
    input wire logic                linkdown_reset_suppress,
    input wire logic                secondary_bus_reset_bit,
    input wire logic [NUM_DS-1:0]   ds_link_up,
    input wire logic [NUM_DS-1:0]   ds_aspm_req,
    input wire phr_pkg::phr_tlp_t   tlp,
    input wire logic                part_reset,
    input wire logic                us_ltssm_hot,
    input wire logic                train_start,
    input wire logic                degraded,
    input wire logic [NUM_DS-1:0]   ds_send_hot_ts1,
    input wire logic [NUM_DS-1:0]   ds_aspm_grant,
    input wire phr_pkg::phr_route_t route
);
    default clocking @(posedge sys_clk); endclocking
    // Frozen cycles carry no expectation, so checks pause while ce is low
    default disable iff (!rstn || !ce);
    // Link was up, then falls with the suppress bit held steady
    sequence s_fall(sup);
        trig.dl_up [*4] ##1
        (!trig.dl_up && linkdown_reset_suppress == sup) [*3];
    endsequence
    // Degraded across the cycle that takes the packet
    sequence s_dgr_pkt(sg, ds);
        degraded && tlp.valid && tlp.self_gen == sg && tlp.to_ds == ds
        ##1 degraded;
    endsequence
    // Routing and power handling while degraded
    a_drop_self_gen: assert property (s_dgr_pkt(1'b1, 1'b0) |->
        route == 3'h1) else $error("self TLP not dropped");
    a_ur_not_ds: assert property (s_dgr_pkt(1'b0, 1'b0) |->
        route == 3'h2) else $error("non downstream TLP not UR");
    a_aspm_free: assert property (degraded ##1 degraded |->
        ds_aspm_grant == $past(ds_aspm_req)) else $error("ASPM grant");
    // Secondary bus reset sends hot-reset sets on live links
    a_sbr_ts1: assert property (secondary_bus_reset_bit |=>
        ds_send_hot_ts1 == $past(ds_link_up)) else $error("SBR TS1");
    // Hot reset triggers and their suppression
    a_link_down_rst: assert property (s_fall(1'b0) |->
        ##[0:3] part_reset) else $error("no reset on link down");
    a_suppress_keep: assert property (s_fall(1'b1) |->
        ##[0:3] (degraded && !part_reset)) else $error("not suppressed");
    a_ts_honoured: assert property (trig.ts_hot_rst [*3] |->
        ##[0:3] (part_reset && us_ltssm_hot)) else $error("TS reset");
    // Training starts once as the reset step ends
    a_train_once: assert property ($fell(part_reset) |->
        ##[0:2] train_start ##1 !train_start) else $error("train pulse");
endmodule

bind phr_ctrl phr_ctrl_props #(.NUM_DS(NUM_DS)) phr_ctrl_props_i (.*);

// *** verification/phr_link_partner.sv ***
// Upstream link partner model driving the hot-reset trigger lines
`timescale 1ns/1ns
module phr_link_partner (
    input  wire logic          sys_clk,
    input  wire logic          link_on,
    input  wire logic          send_hot,
    output phr_pkg::phr_trig_t trig
);
    // Link state and hot-reset training sets change at the clock edge
    initial trig = '0;
    always @(posedge sys_clk) begin
        trig.dl_up      <= link_on;
        trig.ts_hot_rst <= send_hot;
        trig.part_rst   <= 1'b0;
    end
endmodule

// *** verification/phr_ctrl_tb.sv ***
// Self-checking testbench for the partition hot-reset controller
`timescale 1ns/1ns
module phr_ctrl_tb;
    logic                sys_clk, rstn, link_on, send_hot, us_aspm_ok;
    logic                ce;
    logic                linkdown_reset_suppress, secondary_bus_reset_bit;
    logic                part_reset, sticky_keep, train_start, degraded;
    logic                us_ltssm_hot, us_ltssm_detect;
    logic [3:0]          ds_link_up, ds_aspm_req;
    logic [3:0]          ds_send_hot_ts1, ds_aspm_grant;
    phr_pkg::phr_trig_t  trig;
    phr_pkg::phr_tlp_t   tlp;
    phr_pkg::phr_route_t route;
    int                  err_total = 0;
    int                  checks_done = 0;
    int                  trains = 0;
    // Rows: degraded mode, tlp valid/to_ds/self_gen, route fwd/ur/drop
    logic [6:0]          rows [8] = '{7'h24, 7'h34, 7'h2c, 7'h00,
                                      7'h62, 7'h74, 7'h69, 7'h79};

    phr_link_partner phr_link_partner_i (.sys_clk, .link_on, .send_hot,
        .trig);
    phr_ctrl #(.NUM_DS(4)) phr_ctrl_i (.sys_clk, .rstn, .ce, .trig,
        .linkdown_reset_suppress, .secondary_bus_reset_bit, .ds_link_up,
        .ds_aspm_req, .us_aspm_ok, .tlp, .part_reset, .sticky_keep,
        .train_start, .us_ltssm_hot, .us_ltssm_detect, .degraded,
        .ds_send_hot_ts1, .ds_aspm_grant, .route);

    // Clock and training pulse counter
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) if (train_start === 1'b1) trains++;

    task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic test_done();
        if (err_total == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Main sequence
    initial begin
        {rstn, link_on, send_hot, linkdown_reset_suppress} = '0;
        {secondary_bus_reset_bit, us_aspm_ok, ds_aspm_req, tlp} = '0;
        ds_link_up = 4'hb;
        ce = 1'b1;
        settle(4);
        chk({part_reset, degraded, train_start, sticky_keep}, 4'h0);
        @(posedge sys_clk);
        rstn <= 1'b1;
        link_on <= 1'b1;
        settle(8);
        foreach (rows[i]) begin
            if (rows[i][6] && !linkdown_reset_suppress) begin
                @(posedge sys_clk);
                linkdown_reset_suppress <= 1'b1;
                link_on <= 1'b0;
                settle(8);
                chk({degraded, part_reset}, 4'h2);
            end
            @(posedge sys_clk);
            tlp <= rows[i][5:3];
            settle(1);
            chk({1'b0, route}, {1'b0, rows[i][2:0]});
        end
        @(posedge sys_clk);
        tlp <= '0;
        ds_aspm_req <= 4'ha;
        settle(2);
        chk(ds_aspm_grant, 4'ha);
        @(posedge sys_clk);
        linkdown_reset_suppress <= 1'b0;
        settle(6);
        chk({degraded, part_reset}, 4'h2);
        @(posedge sys_clk);
        send_hot <= 1'b1;
        settle(6);
        chk({part_reset, sticky_keep, us_ltssm_hot}, 4'h7);
        @(posedge sys_clk);
        send_hot <= 1'b0;
        link_on <= 1'b1;
        settle(8);
        chk({part_reset, trains[2:0]}, 4'h1);
        @(posedge sys_clk);
        link_on <= 1'b0;
        settle(8);
        chk({part_reset, sticky_keep, us_ltssm_detect}, 4'h7);
        chk(ds_send_hot_ts1, 4'hb);
        @(posedge sys_clk);
        link_on <= 1'b1;
        settle(8);
        chk({part_reset, trains[2:0]}, 4'h2);
        @(posedge sys_clk);
        secondary_bus_reset_bit <= 1'b1;
        settle(20);
        chk(ds_send_hot_ts1, 4'hb);
        @(posedge sys_clk);
        secondary_bus_reset_bit <= 1'b0;
        settle(3);
        chk(ds_send_hot_ts1, 4'h0);
        // Normal mode: upstream ASPM state gates downstream grants
        chk(ds_aspm_grant, 4'h0);
        @(posedge sys_clk);
        us_aspm_ok <= 1'b1;
        settle(2);
        chk(ds_aspm_grant, 4'ha);
        // Clock enable low freezes all state
        @(posedge sys_clk);
        ce <= 1'b0;
        secondary_bus_reset_bit <= 1'b1;
        settle(4);
        chk(ds_send_hot_ts1, 4'h0);
        @(posedge sys_clk);
        ce <= 1'b1;
        settle(3);
        chk(ds_send_hot_ts1, 4'hb);
        // Mid-run reset clears every registered output
        @(posedge sys_clk);
        rstn <= 1'b0;
        settle(2);
        chk({part_reset, degraded, train_start, sticky_keep}, 4'h0);
        chk(ds_send_hot_ts1, 4'h0);
        @(posedge sys_clk);
        rstn <= 1'b1;
        secondary_bus_reset_bit <= 1'b0;
        settle(8);
        chk({part_reset, degraded, us_ltssm_detect}, 4'h0);
        test_done();
    end

    // Watchdog cuts a hung run short
    initial begin
        repeat (2000) @(posedge sys_clk);
        err_total++;
        test_done();
    end
endmodule
